/* mpt_pkg.sv */
`default_nettype none
package mpt_pkg;

    // Array seen by the monitor port
    localparam int ARRAY_DEPTH = 32'h80;
    localparam int ADDR_W      = 32'h7;
    localparam int BYTE_W      = 32'h8;

    // Stream framing: eight data slots then one null slot
    localparam int SLOT_W      = 32'h4;
    localparam int NULL_SLOT   = 32'h8;
    localparam int INIT_CLOCKS = 32'h9;

    // Pin synchroniser lanes
    localparam int PIN_N      = 32'h3;
    localparam int PIN_STREAM = 32'h0;
    localparam int PIN_BUS    = 32'h1;
    localparam int PIN_LINE   = 32'h2;

    // Two-entry buffer between array and serializer
    localparam int BUF_DEPTH = 32'h2;

    // Output hold after a bus clock fall
    localparam int CLK_PERIOD_NS = 32'h8;
    localparam int HOLD_NS       = 32'h12c;
    localparam int HOLD_W        = 32'h6;
    localparam logic [HOLD_W-1:0] HOLD_CYC =
        HOLD_W'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Port mode; Gray codes along init -> stream -> bus
    typedef enum logic [1:0] {
        ST_INIT   = 2'h0,
        ST_STREAM = 2'h1,
        ST_BUS    = 2'h3
    } mpt_state_t;

endpackage
`default_nettype wire

/* mpt_buf.sv */
`timescale 1ns/10ps
`default_nettype none
module mpt_buf #(
    parameter int WIDTH = mpt_pkg::BYTE_W,
    parameter int DEPTH = mpt_pkg::BUF_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    import mpt_pkg::*;

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    logic [WIDTH-1:0] slot_mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    logic             push;
    logic             pop;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready  = (count_reg != FULL_CNT);
    assign out_valid = (count_reg != '0);
    assign out_data  = slot_mem[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            slot_mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            if (pop)
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end

    a_buf_no_overrun: assert property (@(posedge clk_sys) disable iff (sys_rst)
        count_reg <= FULL_CNT)
        else $error("buffer count above depth");

    a_buf_word_held: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
        else $error("stalled word lost or changed");

endmodule // mpt_buf
`default_nettype wire

/* mpt_stream.sv */
`timescale 1ns/10ps
`default_nettype none
module mpt_stream #(
    parameter int                       DEPTH      = mpt_pkg::ARRAY_DEPTH,
    parameter logic [mpt_pkg::ADDR_W-1:0] START_ADDR = '0
) (
    input  wire logic                        clk_sys,
    input  wire logic                        sys_rst,
    input  wire logic                        stream_clock_write_guard,
    input  wire logic                        monitor_bus_clock,
    input  wire logic                        monitor_serial_line_i,
    output logic                             monitor_serial_line_o,
    output logic                             monitor_serial_line_oe,
    input  wire logic                        bus_drive_low,
    input  wire logic                        wr_en,
    input  wire logic [mpt_pkg::ADDR_W-1:0]  wr_addr,
    input  wire logic [mpt_pkg::BYTE_W-1:0]  wr_data,
    output logic                             bus_mode,
    output logic                             bus_clk_fall,
    output logic                             bus_clk_level,
    output logic                             serial_line_level,
    output logic                             write_allowed
);
    import mpt_pkg::*;

    localparam logic [ADDR_W-1:0] LAST_ADDR  = ADDR_W'(DEPTH - 1);
    localparam logic [SLOT_W-1:0] NULL_IDX   = SLOT_W'(NULL_SLOT);
    localparam logic [SLOT_W-1:0] INIT_LAST  = SLOT_W'(INIT_CLOCKS);

    logic [BYTE_W-1:0] array_mem [DEPTH];

    logic [PIN_N-1:0]  sync1_reg;
    logic [PIN_N-1:0]  sync2_reg;
    logic [PIN_N-1:0]  sync3_reg;
    logic [PIN_N-1:0]  lvl_reg;
    logic [PIN_N-1:0]  lvl_next;

    mpt_state_t        state_reg;
    logic              bus_mode_reg;
    logic              bus_clk_fall_reg;
    logic              bus_clk_level_reg;
    logic              line_level_reg;
    logic              write_allowed_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [SLOT_W-1:0] init_cnt_reg;
    logic [SLOT_W-1:0] slot_reg;
    logic [BYTE_W-1:0] shift_reg;
    logic              line_o_reg;
    logic              line_oe_reg;
    logic [HOLD_W-1:0] hold_cnt_reg;

    logic              stream_rise;
    logic              bus_fall;
    logic              tx_step;
    logic              buf_in_valid;
    logic              buf_in_ready;
    logic              buf_out_valid;
    logic              buf_out_ready;
    logic [BYTE_W-1:0] buf_out_data;
    logic              push;
    logic              mem_we;
    logic              msb_w;
    logic              shift_msb_w;

    // Accept a new level only once the second and third stages agree
    function automatic logic [PIN_N-1:0] settle(input logic [PIN_N-1:0] lvl,
                                                input logic [PIN_N-1:0] s2,
                                                input logic [PIN_N-1:0] s3);
        settle = (s3 & ~(s2 ^ s3)) | (lvl & (s2 ^ s3));
    endfunction

    function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
        addr_inc = (a == LAST_ADDR) ? '0 : a + 1'b1;
    endfunction

    // Pin synchronisers and filtered levels
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            lvl_reg   <= '0;
        end
        else
        begin
            sync1_reg <= {monitor_serial_line_i, monitor_bus_clock,
                          stream_clock_write_guard};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            lvl_reg   <= lvl_next;
        end
    end

    assign lvl_next    = settle(lvl_reg, sync2_reg, sync3_reg);
    assign stream_rise = lvl_next[PIN_STREAM] && !lvl_reg[PIN_STREAM];
    assign bus_fall    = lvl_reg[PIN_BUS] && !lvl_next[PIN_BUS];

    // Stream clock drives the serializer only outside bus mode
    assign tx_step = stream_rise && (state_reg != ST_BUS) && !bus_fall &&
                     ((state_reg == ST_STREAM) || (init_cnt_reg == INIT_LAST));

    // Mode control
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_reg    <= ST_INIT;
            bus_mode_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                ST_INIT:
                begin
                    if (bus_fall)
                    begin
                        state_reg    <= ST_BUS;
                        bus_mode_reg <= 1'b1;
                    end
                    else if (tx_step && buf_out_valid)
                        state_reg <= ST_STREAM;
                end
                ST_STREAM:
                begin
                    if (bus_fall)
                    begin
                        state_reg    <= ST_BUS;
                        bus_mode_reg <= 1'b1;
                    end
                end
                ST_BUS:
                begin
                    state_reg    <= ST_BUS;
                    bus_mode_reg <= 1'b1;
                end
                default:
                begin
                    state_reg    <= ST_INIT;
                    bus_mode_reg <= 1'b0;
                end
            endcase
        end
    end

    // Nine stream clocks before data may go out
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            init_cnt_reg <= '0;
        else if (state_reg == ST_INIT && stream_rise && init_cnt_reg != INIT_LAST)
            init_cnt_reg <= init_cnt_reg + 1'b1;
    end

    // Array fetch feeds the buffer in ascending order
    assign buf_in_valid = (state_reg != ST_BUS);
    assign push         = buf_in_valid && buf_in_ready;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            addr_reg <= START_ADDR;
        else if (push)
            addr_reg <= addr_inc(addr_reg);
    end

    // Writes from the two-wire engine need bus mode and the guard pin high
    assign mem_we = wr_en && bus_mode_reg && lvl_reg[PIN_STREAM];

    always_ff @(posedge clk_sys)
    begin
        if (mem_we)
            array_mem[wr_addr] <= wr_data;
    end

    assign buf_out_ready = tx_step && (slot_reg == '0);

    mpt_buf #(
        .WIDTH (BYTE_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (array_mem[addr_reg]),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    assign msb_w       = buf_out_data[BYTE_W-1];
    assign shift_msb_w = shift_reg[BYTE_W-1];

    // Bit slot counter and shifter
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            slot_reg  <= '0;
            shift_reg <= '0;
        end
        else if (tx_step)
        begin
            if (slot_reg == '0)
            begin
                if (buf_out_valid)
                begin
                    shift_reg <= {buf_out_data[BYTE_W-2:0], 1'b0};
                    slot_reg  <= slot_reg + 1'b1;
                end
            end
            else if (slot_reg == NULL_IDX)
                slot_reg <= '0;
            else
            begin
                shift_reg <= {shift_reg[BYTE_W-2:0], 1'b0};
                slot_reg  <= slot_reg + 1'b1;
            end
        end
    end

    // Hold timer started by each bus clock fall
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            hold_cnt_reg <= '0;
        else if (bus_fall)
            hold_cnt_reg <= HOLD_CYC;
        else if (hold_cnt_reg != '0)
            hold_cnt_reg <= hold_cnt_reg - 1'b1;
    end

    // Shared data line: stream bits or two-wire drive
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            line_o_reg  <= 1'b0;
            line_oe_reg <= 1'b0;
        end
        else if (state_reg == ST_BUS)
        begin
            line_o_reg <= 1'b0;
            if (hold_cnt_reg == '0 && !bus_fall)
                line_oe_reg <= bus_drive_low;
        end
        else if (bus_fall)
            line_oe_reg <= 1'b0;
        else if (tx_step)
        begin
            if (slot_reg == '0)
            begin
                line_o_reg  <= msb_w;
                line_oe_reg <= buf_out_valid;
            end
            else if (slot_reg == NULL_IDX)
                line_oe_reg <= 1'b0;
            else
            begin
                line_o_reg  <= shift_msb_w;
                line_oe_reg <= 1'b1;
            end
        end
    end

    // Registered status towards the two-wire engine
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            bus_clk_fall_reg  <= 1'b0;
            bus_clk_level_reg <= 1'b0;
            line_level_reg    <= 1'b0;
            write_allowed_reg <= 1'b0;
        end
        else
        begin
            bus_clk_fall_reg  <= bus_fall && bus_mode_reg;
            bus_clk_level_reg <= lvl_next[PIN_BUS];
            line_level_reg    <= lvl_next[PIN_LINE];
            write_allowed_reg <= bus_mode_reg && lvl_next[PIN_STREAM];
        end
    end

    assign monitor_serial_line_o  = line_o_reg;
    assign monitor_serial_line_oe = line_oe_reg;
    assign bus_mode               = bus_mode_reg;
    assign bus_clk_fall           = bus_clk_fall_reg;
    assign bus_clk_level          = bus_clk_level_reg;
    assign serial_line_level      = line_level_reg;
    assign write_allowed          = write_allowed_reg;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_fall_in_stream;
        (state_reg != ST_BUS) && bus_fall;
    endsequence

    sequence s_tenth_rise;
        (state_reg == ST_INIT) && tx_step && buf_out_valid;
    endsequence

    a_reset_streams: assert property (disable iff (1'b0)
        sys_rst |=> (state_reg == ST_INIT && !bus_mode_reg && !line_oe_reg))
        else $error("port not in transmit-only mode after reset");

    a_mode_switch: assert property (
        s_fall_in_stream |=> (bus_mode_reg && state_reg == ST_BUS && !line_oe_reg))
        else $error("bus clock fall did not enter bus mode");

    a_mode_sticky: assert property (
        bus_mode_reg |=> (bus_mode_reg && state_reg == ST_BUS))
        else $error("left bus mode without reset");

    a_init_quiet: assert property (
        (state_reg == ST_INIT) |-> !line_oe_reg)
        else $error("line driven before initialization done");

    a_first_msb: assert property (
        s_tenth_rise |=> (line_oe_reg && line_o_reg == $past(msb_w) &&
                          state_reg == ST_STREAM))
        else $error("first stream bit is not the byte MSB");

    a_bit_order: assert property (
        (tx_step && slot_reg != '0 && slot_reg != NULL_IDX)
            |=> (line_oe_reg && line_o_reg == $past(shift_msb_w)))
        else $error("stream bit out of order");

    a_null_slot: assert property (
        (tx_step && slot_reg == NULL_IDX) |=> (!line_oe_reg && slot_reg == '0))
        else $error("ninth slot not null");

    a_addr_wrap: assert property (
        (push && addr_reg == LAST_ADDR) |=> (addr_reg == '0))
        else $error("address did not wrap after last byte");

    a_hold_line: assert property (
        (bus_mode_reg && (bus_fall || hold_cnt_reg != '0)) |=> $stable(line_oe_reg))
        else $error("line changed inside hold window");

    a_stream_ignored: assert property (
        (bus_mode_reg && stream_rise) |=> ($stable(slot_reg) && $stable(addr_reg)))
        else $error("stream clock acted in bus mode");

    a_edge_settled: assert property (
        bus_fall |-> (!sync2_reg[PIN_BUS] && !sync3_reg[PIN_BUS]))
        else $error("bus clock fall taken before stages agree");

endmodule // mpt_stream
`default_nettype wire

/* mpt_host.sv */
`timescale 1ns/10ps
`default_nettype none
// Display host: clocks the stream pin and samples the line just before each next rise
module mpt_host (
    input  wire logic        run,
    input  wire logic        slow,
    input  wire logic        line_level,
    input  wire logic        line_oe,
    output var logic         stream_clk,
    output var logic [15:0]  rises,
    output var logic         got_bit,
    output var logic         got_oe
);
    initial
    begin
        stream_clk = 1'b0;
        rises      = 16'h0;
        got_bit    = 1'b0;
        got_oe     = 1'b0;
        forever
        begin
            // Clock stands low while not running
            wait (run === 1'b1);
            #2.5;
            stream_clk = 1'b1;
            #62.5;
            stream_clk = 1'b0;
            // Slow host stretches the low phase
            if (slow)
                #2000;
            #60;
            got_bit = line_level;
            got_oe  = line_oe;
            rises   = rises + 16'h1;
        end
    end
endmodule // mpt_host
`default_nettype wire

/* mpt_stream_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module mpt_stream_tb;
    import mpt_pkg::*;
    logic               clk_sys, sys_rst, mbc, guard, drive_low, wr_en, run, slow;
    logic [ADDR_W-1:0]  wr_addr;
    logic [BYTE_W-1:0]  wr_data;
    logic               line_o, line_oe, bus_mode, bus_fall, host_clk, got_bit, got_oe;
    logic               w_allowed, bus_lvl, line_lvl;
    logic [15:0]        rises;
    int                 bad_count, num_checks, cyc;
    // Pull-up on the shared data line
    wire logic          line = line_oe ? line_o : 1'b1;

    mpt_stream uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .stream_clock_write_guard(host_clk | guard), .monitor_bus_clock(mbc),
        .monitor_serial_line_i(line), .monitor_serial_line_o(line_o),
        .monitor_serial_line_oe(line_oe), .bus_drive_low(drive_low), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .bus_mode(bus_mode),
        .bus_clk_fall(bus_fall), .bus_clk_level(bus_lvl), .serial_line_level(line_lvl),
        .write_allowed(w_allowed));

    mpt_host host (.run(run), .slow(slow), .line_level(line), .line_oe(line_oe),
        .stream_clk(host_clk), .rises(rises), .got_bit(got_bit), .got_oe(got_oe));

    initial
    begin
        clk_sys = 1'b0;
        forever
            #4 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] pat(input logic [6:0] a);
        return {a[0], a} ^ 8'h3c;
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            conclude();
        end
    end

    task automatic clocks(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic do_reset;
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        clocks(8);
        sys_rst <= 1'b0;
        clocks(2);
    endtask

    task automatic next_slot(output logic b, output logic e);
        logic [15:0] r0;
        r0 = rises;
        wait (rises != r0);
        b = got_bit;
        e = got_oe;
    endtask

    task automatic t_enter_bus;
        check("mode_after_reset", bus_mode, 1'b0);
        clocks(1);
        mbc <= 1'b0;
        clocks(8);
        check("mode_after_fall", bus_mode, 1'b1);
        check("bus_level_after_fall", bus_lvl, 1'b0);
        check("oe_after_fall", line_oe, 1'b0);
        $display("done enter_bus");
    endtask

    task automatic t_load;
        guard <= 1'b1;
        clocks(6);
        check("write_allowed_hi", w_allowed, 1'b1);
        for (int a = 0; a < ARRAY_DEPTH; a++)
        begin
            @(posedge clk_sys);
            wr_en   <= 1'b1;
            wr_addr <= ADDR_W'(a);
            wr_data <= pat(ADDR_W'(a));
            @(posedge clk_sys);
            wr_en   <= 1'b0;
        end
        guard <= 1'b0;
        clocks(6);
        check("write_allowed_lo", w_allowed, 1'b0);
        // Refused write; the stream later must still show the old byte
        wr_en   <= 1'b1;
        wr_addr <= 7'h05;
        wr_data <= 8'h00;
        clocks(1);
        wr_en   <= 1'b0;
        $display("done load");
    endtask

    task automatic t_hold;
        int  n;
        logic fell;
        fell = 1'b0;
        mbc <= 1'b1;
        clocks(8);
        check("bus_level_hi", bus_lvl, 1'b1);
        check("line_level_hi", line_lvl, 1'b1);
        mbc <= 1'b0;
        n = 0;
        while (fell !== 1'b1 && n < 20)
        begin
            clocks(1);
            n++;
            fell = bus_fall;
        end
        check("bus_fall_pulse", fell, 1'b1);
        // Ask for the line low right after the fall; the hold window must delay it
        drive_low <= 1'b1;
        n = 0;
        while (line_oe !== 1'b1 && n < 80)
        begin
            clocks(1);
            n++;
        end
        check("hold_min", 16'(n >= 38), 16'h1);
        check("hold_max", 16'(n <= 48), 16'h1);
        check("bus_line_o", line_o, 1'b0);
        clocks(4);
        check("line_level_lo", line_lvl, 1'b0);
        drive_low <= 1'b0;
        mbc <= 1'b1;
        clocks(4);
        $display("done hold");
    endtask

    task automatic t_persist;
        logic b, e;
        run = 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            next_slot(b, e);
            check("persist_oe", e, 1'b0);
        end
        run = 1'b0;
        check("persist_mode", bus_mode, 1'b1);
        clocks(40);
        $display("done persist");
    endtask

    task automatic t_stream;
        logic       b, e;
        logic [7:0] v;
        logic [6:0] a;
        a = 7'h0;
        run = 1'b1;
        for (int i = 0; i < INIT_CLOCKS; i++)
        begin
            next_slot(b, e);
            check("sync_oe", e, 1'b0);
        end
        for (int n = 0; n < 130; n++)
        begin
            slow = (n == 3);
            v = 8'h0;
            for (int k = 0; k < BYTE_W; k++)
            begin
                next_slot(b, e);
                check("data_oe", e, 1'b1);
                v = {v[6:0], b};
            end
            if (n == 0)
                a = v[6:0] ^ 7'h3c;
            check("byte", v, pat(a));
            next_slot(b, e);
            check("null_oe", e, 1'b0);
            a = a + 7'h1;
        end
        check("stream_mode", bus_mode, 1'b0);
        $display("done stream");
    endtask

    task automatic t_switch;
        logic b, e;
        mbc <= 1'b0;
        clocks(8);
        check("switch_mode", bus_mode, 1'b1);
        check("switch_oe", line_oe, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            next_slot(b, e);
            check("switch_slot_oe", e, 1'b0);
        end
        run = 1'b0;
        $display("done switch");
    endtask

    initial
    begin
        sys_rst   = 1'b1;
        mbc       = 1'b1;
        guard     = 1'b0;
        drive_low = 1'b0;
        wr_en     = 1'b0;
        wr_addr   = 7'h0;
        wr_data   = 8'h0;
        run       = 1'b0;
        slow      = 1'b0;
        bad_count = 0;
        num_checks = 0;
        cyc       = 0;
        do_reset();
        t_enter_bus();
        t_load();
        t_hold();
        t_persist();
        mbc <= 1'b1;
        do_reset();
        t_stream();
        t_switch();
        conclude();
    end
endmodule // mpt_stream_tb
`default_nettype wire
